// >>> design/spls_shifter.sv
// eight-stage serial shifter with a storage latch and three-state parallel outputs
// assumes host pins arrive asynchronously and are oversampled by the 50 MHz ref_clk_i;
// each pin level must stay at least two clock periods for it to be seen
`timescale 1ns/1ps

// Behaviour
// - a rising shift clock with clear idle shifts serial data into stage one and moves all stages up
// - with clear idle and no rising shift clock the shift stages and cascade output hold
// - a rising latch clock copies every shift stage into the latch, which feeds the parallel outputs
// - without a rising latch clock the latch and parallel output values hold
// - a high output enable releases all eight parallel outputs while storage keeps working
// - the latch follows only its clock and the shift stages only clear and shift clock
// - a low clear pin empties the shift stages and cascade output and leaves the latch alone
// - a low output enable drives the latch values onto the parallel outputs uninverted
// - the cascade output always drives the eighth shift stage uninverted
// - the output enable never touches the cascade output
module spls_shifter (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // host pins
    input wire logic serial_data_i,
    input wire logic shift_clk_i,
    input wire logic latch_clk_i,
    input wire logic shift_clear_n_i,
    input wire logic out_enable_n_i,
    // parallel outputs, three-state as data plus enable
    output logic [spls_pkg::STAGE_W-1:0] parallel_outputs_o,
    output logic [spls_pkg::STAGE_W-1:0] parallel_outputs_oe_o,
    // cascade output, always driven
    output logic cascade_serial_out_o
);

    logic [spls_pkg::PIN_W-1:0] pins_raw;
    logic [spls_pkg::PIN_W-1:0] pins_f;
    logic data_f, shclk_f, lclk_f, clr_n_f, oe_n_f;
    logic shclk_prev_q, shclk_prev_d;
    logic lclk_prev_q, lclk_prev_d;
    logic shift_rise, latch_rise;
    logic [spls_pkg::STAGE_W-1:0] shift_stages_q, shift_stages_d;
    logic [spls_pkg::STAGE_W-1:0] latch_bits_q, latch_bits_d;
    logic [spls_pkg::STAGE_W-1:0] drive_q, drive_d;

    // gather pins so one synchroniser instance covers all of them
    assign pins_raw[spls_pkg::PIN_DATA] = serial_data_i;
    assign pins_raw[spls_pkg::PIN_SHCLK] = shift_clk_i;
    assign pins_raw[spls_pkg::PIN_LCLK] = latch_clk_i;
    assign pins_raw[spls_pkg::PIN_CLR_N] = shift_clear_n_i;
    assign pins_raw[spls_pkg::PIN_OE_N] = out_enable_n_i;

    // data shares the clock's path, so both keep their relative timing
    spls_pin_sync #(
        .WIDTH(spls_pkg::PIN_W),
        .RESET_VAL(spls_pkg::PIN_RST)
    ) u_pin_sync (
        .ref_clk_i(ref_clk_i),
        .rstn_i(rstn_i),
        .pin_i(pins_raw),
        .level_o(pins_f)
    );

    // filtered pin levels
    assign data_f = pins_f[spls_pkg::PIN_DATA];
    assign shclk_f = pins_f[spls_pkg::PIN_SHCLK];
    assign lclk_f = pins_f[spls_pkg::PIN_LCLK];
    assign clr_n_f = pins_f[spls_pkg::PIN_CLR_N];
    assign oe_n_f = pins_f[spls_pkg::PIN_OE_N];

    // edge detection on the filtered clocks; falling edges do nothing
    always_comb begin
        shclk_prev_d = shclk_f;
        lclk_prev_d = lclk_f;
    end

    assign shift_rise = shclk_f & ~shclk_prev_q;
    assign latch_rise = lclk_f & ~lclk_prev_q;

    // shift stages: clear wins over a shift edge; the clear is a level here,
    // so it acts a few clocks after the pin instead of instantly
    always_comb begin
        shift_stages_d = shift_stages_q; // hold otherwise
        if (!clr_n_f) begin
            shift_stages_d = spls_pkg::SHIFT_CLEAR;
        end else if (shift_rise) begin
            // stage one takes the pin, the rest move up
            shift_stages_d = {shift_stages_q[spls_pkg::STAGE_W-2:0], data_f};
        end
    end

    // latch: only its own clock matters; a shift edge in the same cycle is
    // not yet visible, so the latch then takes the pre-shift word
    always_comb begin
        latch_bits_d = latch_bits_q;
        if (latch_rise) begin
            latch_bits_d = shift_stages_q;
        end
    end

    // output drive follows the active-low enable, nothing else
    always_comb begin
        drive_d = oe_n_f ? spls_pkg::DRIVE_RST : spls_pkg::DRIVE_ALL;
    end

    // register stage for all state
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            shclk_prev_q <= 1'b0;
            lclk_prev_q <= 1'b0;
            shift_stages_q <= spls_pkg::SHIFT_RST;
            latch_bits_q <= spls_pkg::LATCH_RST;
            drive_q <= spls_pkg::DRIVE_RST;
        end else begin
            shclk_prev_q <= shclk_prev_d;
            lclk_prev_q <= lclk_prev_d;
            shift_stages_q <= shift_stages_d;
            latch_bits_q <= latch_bits_d;
            drive_q <= drive_d;
        end
    end

    // outputs straight from flops; data stays valid even while released
    assign parallel_outputs_o = latch_bits_q;
    assign parallel_outputs_oe_o = drive_q;
    assign cascade_serial_out_o = shift_stages_q[spls_pkg::STAGE_W-1];

    // shift edge moves the whole word up by one
    a_shift_move: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (shift_rise && clr_n_f) |=> (shift_stages_q ==
            {$past(shift_stages_q[spls_pkg::STAGE_W-2:0]), $past(data_f)}))
        else $error("shift edge did not move stages");

    // cascade output takes the old seventh stage
    a_cascade_take: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (shift_rise && clr_n_f) |=> (cascade_serial_out_o ==
            $past(shift_stages_q[spls_pkg::STAGE_W-2])))
        else $error("cascade output missed seventh stage");

    // no shift edge, no change
    a_shift_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (!shift_rise && clr_n_f) |=> ($stable(shift_stages_q) && $stable(cascade_serial_out_o)))
        else $error("shift stages changed without a shift edge");

    // latch edge copies the word and the outputs show it
    a_latch_copy: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        latch_rise |=> (parallel_outputs_o == $past(shift_stages_q)))
        else $error("latch edge did not capture shift stages");

    // without a latch edge latch and outputs hold
    a_latch_hold: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        !latch_rise |=> ($stable(latch_bits_q) && $stable(parallel_outputs_o)))
        else $error("latch changed without a latch edge");

    // high enable releases all outputs one clock later
    a_out_release: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        oe_n_f |=> (parallel_outputs_oe_o == spls_pkg::DRIVE_RST))
        else $error("parallel outputs not released");

    // enable toggling leaves the shift stages alone
    a_enable_indep: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ($changed(oe_n_f) && !shift_rise && clr_n_f) |=> $stable(shift_stages_q))
        else $error("output enable disturbed shift stages");

    // clear empties the stages but spares the latch
    a_clear_stages: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (!clr_n_f && !latch_rise) |=> ((shift_stages_q == spls_pkg::SHIFT_CLEAR) &&
            !cascade_serial_out_o && $stable(latch_bits_q)))
        else $error("clear misbehaved");

    // low enable drives every output with latch data
    a_out_drive: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (!oe_n_f && !latch_rise) |=> ((parallel_outputs_oe_o == spls_pkg::DRIVE_ALL) &&
            (parallel_outputs_o == $past(latch_bits_q))))
        else $error("parallel outputs not driven with latch data");

    // cascade output only moves on a shift edge or a clear
    a_cascade_cause: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        $changed(cascade_serial_out_o) |-> ($past(shift_rise) || !$past(clr_n_f) ||
            !$past(rstn_i)))
        else $error("cascade output changed without cause");

    // cascade keeps shifting while outputs are released
    a_cascade_hiz: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (oe_n_f && shift_rise && clr_n_f) |=> (cascade_serial_out_o ==
            $past(shift_stages_q[spls_pkg::STAGE_W-2])))
        else $error("cascade output stopped while released");

    // a shift clock held high must count as one edge, not one per cycle
    a_rise_once: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        shift_rise |=> !shift_rise)
        else $error("shift edge counted twice");

    // a latch clock held high must capture once only
    a_latch_once: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        latch_rise |=> !latch_rise)
        else $error("latch edge counted twice");

    // a falling shift clock leaves stages and cascade alone
    a_fall_ignored: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (!shclk_f && shclk_prev_q && clr_n_f) |=> ($stable(shift_stages_q) &&
            $stable(cascade_serial_out_o)))
        else $error("falling shift clock moved stages");

    // serial data wiggling between edges is ignored
    a_data_ignored: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ($changed(data_f) && !shift_rise && clr_n_f) |=> $stable(shift_stages_q))
        else $error("serial data changed stages without an edge");

    // all eight enables move together, never a partial drive
    a_oe_uniform: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (parallel_outputs_oe_o == spls_pkg::DRIVE_ALL) ||
            (parallel_outputs_oe_o == spls_pkg::DRIVE_RST))
        else $error("parallel output enables disagree");

    // a latch edge alone never disturbs the shift stages
    a_latch_spares: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        (latch_rise && !shift_rise && clr_n_f) |=> $stable(shift_stages_q))
        else $error("latch edge disturbed shift stages");

    // enable toggling leaves the cascade output alone
    a_enable_cascade: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ($changed(oe_n_f) && !shift_rise && clr_n_f) |=> $stable(cascade_serial_out_o))
        else $error("output enable disturbed cascade output");

    // enable toggling leaves the latch alone
    a_enable_latch: assert property (@(posedge ref_clk_i) disable iff (!rstn_i)
        ($changed(oe_n_f) && !latch_rise) |=> $stable(latch_bits_q))
        else $error("output enable disturbed latch");

endmodule : spls_shifter

// >>> design/spls_pkg.sv
// shared constants for the latched serial-to-parallel shifter
// assumes one 50 MHz system clock and five pins sampled from outside that domain
package spls_pkg;

    // number of shift stages and latch bits
    localparam int unsigned STAGE_W = 8;
    // number of sampled control and data pins
    localparam int unsigned PIN_W = 5;

    // bit positions of the pins inside the sampled pin vector
    localparam int unsigned PIN_DATA = 0;
    localparam int unsigned PIN_SHCLK = 1;
    localparam int unsigned PIN_LCLK = 2;
    localparam int unsigned PIN_CLR_N = 3;
    localparam int unsigned PIN_OE_N = 4;

    // pin levels assumed while the system reset holds: clocks low, clear and enable idle
    localparam logic [PIN_W-1:0] PIN_RST = 5'h18;

    // reset values of the storage
    localparam logic [STAGE_W-1:0] SHIFT_RST = 8'h00;
    localparam logic [STAGE_W-1:0] LATCH_RST = 8'h00;
    localparam logic [STAGE_W-1:0] DRIVE_RST = 8'h00;
    // value the shift stages take under the clear pin
    localparam logic [STAGE_W-1:0] SHIFT_CLEAR = 8'h00;
    // enable pattern while all parallel outputs drive
    localparam logic [STAGE_W-1:0] DRIVE_ALL = 8'hff;

endpackage : spls_pkg

// >>> design/spls_pin_sync.sv
// three-flop pin synchroniser with an agreement filter
// assumes inputs arrive from outside the ref_clk_i domain
`timescale 1ns/1ps
module spls_pin_sync #(
    parameter int unsigned WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    // clock and reset
    input wire logic ref_clk_i,
    input wire logic rstn_i,
    // raw pins and filtered levels
    input wire logic [WIDTH-1:0] pin_i,
    output logic [WIDTH-1:0] level_o
);

    logic [WIDTH-1:0] ff1_q, ff2_q, ff3_q, level_q;
    logic [WIDTH-1:0] level_d;

    // a change counts only once the second and third flops agree;
    // the first flop feeds nothing but the second to keep metastability contained
    always_comb begin
        level_d = level_q;
        for (int i = 0; i < int'(WIDTH); i++) begin
            if (ff2_q[i] == ff3_q[i]) begin
                level_d[i] = ff3_q[i];
            end
        end
    end

    // register stage
    always_ff @(posedge ref_clk_i) begin
        if (!rstn_i) begin
            ff1_q <= RESET_VAL;
            ff2_q <= RESET_VAL;
            ff3_q <= RESET_VAL;
            level_q <= RESET_VAL;
        end else begin
            ff1_q <= pin_i;
            ff2_q <= ff1_q;
            ff3_q <= ff2_q;
            level_q <= level_d;
        end
    end

    assign level_o = level_q;

endmodule : spls_pin_sync

// >>> tb/spls_host.sv
// host model driving the five pins of the shifter
// assumes the bench calls its tasks and owns ref_clk_i
`timescale 1ns/1ps
module spls_host (
    // clock
    input wire logic ref_clk_i,
    // pins towards the shifter
    output logic serial_data_o,
    output logic shift_clk_o,
    output logic latch_clk_o,
    output logic shift_clear_n_o,
    output logic out_enable_n_o
);
    // idle pins: clocks low, clear and enable inactive
    initial begin
        serial_data_o = 1'b0;
        shift_clk_o = 1'b0;
        latch_clk_o = 1'b0;
        shift_clear_n_o = 1'b1;
        out_enable_n_o = 1'b1;
    end
    // step off the edge so pins never move on the sampling edge
    task automatic step(input int n);
        repeat (n) @(posedge ref_clk_i);
        #1;
    endtask : step
    // data settles before the rise and holds past it
    task automatic shift_bit(input logic b);
        serial_data_o = b;
        step(3);
        shift_clk_o = 1'b1;
        step(3);
        serial_data_o = ~b; // hold over: line no longer shows the bit
        shift_clk_o = 1'b0;
        step(3);
    endtask : shift_bit
    // latch only after the last shift has settled, never together
    task automatic latch_pulse();
        latch_clk_o = 1'b1;
        step(3);
        latch_clk_o = 1'b0;
        step(3);
    endtask : latch_pulse
    // level pins, then wait past the five-clock pin latency
    task automatic set_ctl(input logic clr_n, input logic oe_n);
        shift_clear_n_o = clr_n;
        out_enable_n_o = oe_n;
        step(6);
    endtask : set_ctl
endmodule : spls_host

// >>> tb/testbench.sv
// self-checking bench comparing the shifter with an integer model
// assumes the host model in spls_host and a 50 MHz clock
`timescale 1ns/1ps
module testbench;
    logic ref_clk_i = 1'b0;
    logic rstn_i = 1'b0;
    logic sdata, sclk, lclk, clr_n, oe_n, cascade;
    logic [spls_pkg::STAGE_W-1:0] par, par_oe;
    int n_errors = 0;
    int comparisons = 0;
    int cycles = 0;
    int sr = 0; // model shift stages
    int lr = 0; // model latch
    bit clr_m = 1'b0;
    logic [31:0] rnd = 32'hf9dc_9a67;

    // clock and a ceiling on run length
    always #10 ref_clk_i = ~ref_clk_i;
    always @(posedge ref_clk_i) begin
        cycles++;
        if (cycles == 5000) begin
            n_errors++;
            give_verdict();
        end
    end

    spls_host i_spls_host (.ref_clk_i(ref_clk_i), .serial_data_o(sdata), .shift_clk_o(sclk),
        .latch_clk_o(lclk), .shift_clear_n_o(clr_n), .out_enable_n_o(oe_n));
    spls_shifter i_spls_shifter (.ref_clk_i(ref_clk_i), .rstn_i(rstn_i),
        .serial_data_i(sdata), .shift_clk_i(sclk), .latch_clk_i(lclk),
        .shift_clear_n_i(clr_n), .out_enable_n_i(oe_n), .parallel_outputs_o(par),
        .parallel_outputs_oe_o(par_oe), .cascade_serial_out_o(cascade));

    function automatic logic [31:0] xorshift(input logic [31:0] x);
        x ^= x << 13;
        x ^= x >> 17;
        x ^= x << 5;
        return x;
    endfunction : xorshift

    task automatic check(input string what, input logic [7:0] seen, input logic [7:0] exp);
        comparisons++;
        if (seen !== exp) begin
            n_errors++;
            $display("unexpected %s expected %h seen %h", what, exp, seen);
        end
    endtask : check

    // one bit through the host, model stepped alongside
    task automatic shift_one(input logic b);
        i_spls_host.shift_bit(b);
        sr = clr_m ? 0 : ((sr << 1) | b) & 255;
        check("cascade", {7'h00, cascade}, 8'(sr >> 7));
        check("parallel", par, 8'(lr));
    endtask : shift_one

    task automatic latch_one();
        i_spls_host.latch_pulse();
        lr = sr;
        check("latched", par, 8'(lr));
        check("cascade kept", {7'h00, cascade}, 8'(sr >> 7));
    endtask : latch_one

    task automatic give_verdict();
        if (n_errors == 0 && comparisons > 0) $display("RESULT: PASS");
        else $display("RESULT: FAIL");
        $finish;
    endtask : give_verdict

    initial begin
        repeat (20) @(posedge ref_clk_i);
        #1 rstn_i = 1'b1;
        check("reset oe", par_oe, 8'h00);
        check("reset cascade", {7'h00, cascade}, 8'h00);
        i_spls_host.set_ctl(1'b1, 1'b0);
        check("enable", par_oe, spls_pkg::DRIVE_ALL);
        // random words shifted in full, then latched
        for (int w = 0; w < 3; w++) begin
            rnd = xorshift(rnd);
            for (int i = 7; i >= 0; i--) shift_one(rnd[i]);
            latch_one();
        end
        // clear with outputs released: latch kept, shifts overridden
        clr_m = 1'b1;
        i_spls_host.set_ctl(1'b0, 1'b1);
        sr = 0;
        check("released", par_oe, 8'h00);
        check("clear keeps latch", par, 8'(lr));
        shift_one(1'b1);
        clr_m = 1'b0;
        i_spls_host.set_ctl(1'b1, 1'b1);
        shift_one(1'b1);
        latch_one();
        i_spls_host.set_ctl(1'b1, 1'b0);
        check("enable again", par_oe, spls_pkg::DRIVE_ALL);
        check("shown", par, 8'(lr));
        give_verdict();
    end
endmodule : testbench
